// ==== rdes_pkg.sv ====
// Package for the reader error and status register group.
// Assumes an 8-bit register port with 6-bit addresses from the host port logic.
package rdes_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [5:0] ERR_ADDR = 6'h06;
  localparam logic [5:0] STAT1_ADDR = 6'h07;
  localparam logic [5:0] STAT2_ADDR = 6'h08;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] ERR_RST = 8'h00;
  localparam logic [7:0] STAT1_RST = 8'h21;
  localparam logic [7:0] STAT2_RST = 8'h00;
  // ----------------------------------------
  // Error word fields
  // ----------------------------------------
  localparam int ERR_WRITE_B = 7;
  localparam int ERR_HEAT_B = 6;
  localparam int ERR_OVR_B = 4;
  localparam int ERR_CLASH_B = 3;
  localparam int ERR_CSUM_B = 2;
  localparam int ERR_PAR_B = 1;
  localparam int ERR_FRAME_B = 0;
  localparam logic [7:0] ERR_USED_MASK = 8'hdf;
  // ----------------------------------------
  // Status word 1 fields
  // ----------------------------------------
  localparam int S1_CGOOD_B = 6;
  localparam int S1_CDONE_B = 5;
  localparam int S1_IRQ_B = 4;
  localparam int S1_TACT_B = 3;
  localparam int S1_HI_B = 1;
  localparam int S1_LO_B = 0;
  // ----------------------------------------
  // Status word 2 fields
  // ----------------------------------------
  localparam int S2_HCLR_B = 7;
  localparam int S2_FAST_B = 6;
  localparam int S2_CIPH_B = 3;
  localparam int S2_MODEM_MSB = 2;
  // ----------------------------------------
  // FIFO and timer
  // ----------------------------------------
  localparam logic [6:0] FIFO_DEPTH = 7'h40;
  localparam logic [1:0] GATE_OFF = 2'h0;
endpackage

// ==== rdes_fifo_alert.sv ====
// FIFO watermark comparator for the status group.
// Assumes level and watermark come from logic on the same clock.
`timescale 1ns/1ps
module rdes_fifo_alert
  import rdes_pkg::*;
(
  // Fill state
  input wire logic [6:0] fifoByteCount,
  input wire logic [5:0] fifoWatermark,
  // Alerts
  output logic fifoNearlyFull,
  output logic fifoNearlyEmpty
);
  logic [6:0] freeSpace;
  always_comb begin
    freeSpace = 7'(FIFO_DEPTH - fifoByteCount);
    fifoNearlyFull = freeSpace <= {1'b0, fifoWatermark};
    fifoNearlyEmpty = fifoByteCount <= {1'b0, fifoWatermark};
  end
endmodule

// ==== rdes_status_regs.sv ====
// Error word and two status words of the reader front end.
// Assumes all event inputs are single-cycle pulses on clk from core logic;
// the gate pin level is not an input on purpose.
`timescale 1ns/1ps
module rdes_status_regs
  import rdes_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [5:0] regAddr,
  input wire logic regWr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // Command and fault events
  input wire logic cmdStart,
  input wire logic [7:0] faultSet,
  input wire logic dieOverLimit,
  // Checksum coprocessor
  input wire logic checksumBusy,
  input wire logic [15:0] checksumResult,
  input wire logic checksumComputeCmd,
  input wire logic checksumDone,
  // Interrupt requests and enables
  input wire logic [7:0] mainIrqReq,
  input wire logic [7:0] mainIrqEnables,
  input wire logic [7:0] miscIrqReq,
  input wire logic [7:0] miscIrqEnables,
  // Timer
  input wire logic timerRun,
  input wire logic [1:0] timerGateSelect,
  input wire logic timerGateEnabled,
  // FIFO
  input wire logic [6:0] fifoByteCount,
  input wire logic [5:0] fifoWatermark,
  // Radio and cipher
  input wire logic [2:0] radioFsmState,
  input wire logic authSuccess,
  // Status outputs
  output logic busFilterFastForce,
  output logic cipherActive,
  output logic irqPending
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] errFf, nxt_err;
  logic [7:0] stat1Ff, nxt_stat1;
  logic fastFf, nxt_fast;
  logic ciphFf, nxt_ciph;
  logic hclrFf, nxt_hclr;
  logic [2:0] modemFf, nxt_modem;
  logic [7:0] rdFf, nxt_rd;
  logic csumDoneFf, nxt_csumDone;
  logic csumCmdFf, nxt_csumCmd;
  logic nearlyFull, nearlyEmpty;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] target);
    hit = a == target;
  endfunction

  rdes_fifo_alert uAlert (
    .fifoByteCount(fifoByteCount),
    .fifoWatermark(fifoWatermark),
    .fifoNearlyFull(nearlyFull),
    .fifoNearlyEmpty(nearlyEmpty)
  );

  // ----------------------------------------
  // Error word
  // ----------------------------------------
  always_comb begin
    nxt_err = errFf;
    if (cmdStart) begin
      nxt_err = errFf & (8'h01 << ERR_HEAT_B);
    end
    // Overheat clear only while cool; a fresh fault in the same cycle wins
    if (regWr && hit(regAddr, STAT2_ADDR) && regWrData[S2_HCLR_B] && !dieOverLimit) begin
      nxt_err[ERR_HEAT_B] = 1'b0;
    end
    nxt_err = (nxt_err | faultSet) & ERR_USED_MASK;
  end

  // ----------------------------------------
  // Status word 1
  // ----------------------------------------
  always_comb begin
    nxt_csumCmd = csumCmdFf;
    if (checksumComputeCmd) begin
      nxt_csumCmd = 1'b1;
    end else if (cmdStart) begin
      nxt_csumCmd = 1'b0;
    end
    nxt_csumDone = csumDoneFf;
    // Completion beats a clear in the same cycle so a finish is never lost
    if (checksumDone && csumCmdFf) begin
      nxt_csumDone = 1'b1;
    end else if (checksumComputeCmd || cmdStart) begin
      nxt_csumDone = 1'b0;
    end
    nxt_stat1 = 8'h00;
    // Undefined during frames by nature; zero while busy
    nxt_stat1[S1_CGOOD_B] = !checksumBusy && (checksumResult == 16'h0000);
    nxt_stat1[S1_CDONE_B] = nxt_csumDone;
    nxt_stat1[S1_IRQ_B] = |(mainIrqReq & mainIrqEnables) |
                          |(miscIrqReq & miscIrqEnables);
    if (timerGateSelect != GATE_OFF) begin
      nxt_stat1[S1_TACT_B] = timerGateEnabled;
    end else begin
      nxt_stat1[S1_TACT_B] = timerRun;
    end
    nxt_stat1[S1_HI_B] = nearlyFull;
    nxt_stat1[S1_LO_B] = nearlyEmpty;
  end

  // ----------------------------------------
  // Status word 2 and read port
  // ----------------------------------------
  always_comb begin
    nxt_fast = fastFf;
    nxt_hclr = hclrFf;
    nxt_ciph = ciphFf;
    if (regWr && hit(regAddr, STAT2_ADDR)) begin
      nxt_fast = regWrData[S2_FAST_B];
      nxt_hclr = regWrData[S2_HCLR_B];
      if (!regWrData[S2_CIPH_B]) begin
        nxt_ciph = 1'b0;
      end
    end
    if (authSuccess) begin
      nxt_ciph = 1'b1;
    end
    nxt_modem = radioFsmState;
    case (regAddr)
      ERR_ADDR: nxt_rd = errFf;
      STAT1_ADDR: nxt_rd = stat1Ff;
      STAT2_ADDR: nxt_rd = {hclrFf, fastFf, 2'b00, ciphFf, modemFf};
      default: nxt_rd = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      errFf <= ERR_RST;
      stat1Ff <= STAT1_RST;
      fastFf <= STAT2_RST[S2_FAST_B];
      hclrFf <= STAT2_RST[S2_HCLR_B];
      ciphFf <= STAT2_RST[S2_CIPH_B];
      modemFf <= STAT2_RST[S2_MODEM_MSB:0];
      rdFf <= 8'h00;
      csumDoneFf <= STAT1_RST[S1_CDONE_B];
      csumCmdFf <= 1'b0;
    end else begin
      errFf <= nxt_err;
      stat1Ff <= nxt_stat1;
      fastFf <= nxt_fast;
      hclrFf <= nxt_hclr;
      ciphFf <= nxt_ciph;
      modemFf <= nxt_modem;
      rdFf <= nxt_rd;
      csumDoneFf <= nxt_csumDone;
      csumCmdFf <= nxt_csumCmd;
    end
  end

  assign regRdData = rdFf;
  assign busFilterFastForce = fastFf;
  assign cipherActive = ciphFf;
  assign irqPending = stat1Ff[S1_IRQ_B];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Set, then held unless software wrote any register in between
  sequence s_ciph_held;
    cipherActive ##1 (cipherActive || $past(regWr));
  endsequence

  a_err_clear: assert property (@(posedge clk) disable iff (rst)
    cmdStart && faultSet == 8'h00 && !regWr |=> errFf == ($past(errFf) & 8'h40))
    else $error("error word not cleared on command start");
  a_err_nowrite: assert property (@(posedge clk) disable iff (rst)
    regWr && hit(regAddr, ERR_ADDR) && !cmdStart && faultSet == 8'h00 |=> $stable(errFf))
    else $error("error word changed by write");
  a_fault_set: assert property (@(posedge clk) disable iff (rst)
    faultSet != 8'h00 |=>
    (errFf & $past(faultSet) & ERR_USED_MASK) == ($past(faultSet) & ERR_USED_MASK))
    else $error("fault event lost");
  a_cgood_busy: assert property (@(posedge clk) disable iff (rst)
    checksumBusy |=> !stat1Ff[S1_CGOOD_B])
    else $error("checksum good high while busy");
  a_irq_pend: assert property (@(posedge clk) disable iff (rst)
    |(mainIrqReq & mainIrqEnables) |=> irqPending)
    else $error("enabled request not pending");
  a_fifo_hi: assert property (@(posedge clk) disable iff (rst)
    7'(FIFO_DEPTH - fifoByteCount) <= {1'b0, fifoWatermark} |=> stat1Ff[S1_HI_B])
    else $error("nearly full missing");
  a_fifo_lo: assert property (@(posedge clk) disable iff (rst)
    fifoByteCount > {1'b0, fifoWatermark} |=> !stat1Ff[S1_LO_B])
    else $error("nearly empty wrong");
  a_ciph_set: assert property (@(posedge clk) disable iff (rst)
    authSuccess |=> s_ciph_held)
    else $error("cipher flag not held");
  a_heat_hold: assert property (@(posedge clk) disable iff (rst)
    regWr && hit(regAddr, STAT2_ADDR) && dieOverLimit && errFf[ERR_HEAT_B]
    |=> errFf[ERR_HEAT_B])
    else $error("overheat cleared while hot");
  a_timer_gate: assert property (@(posedge clk) disable iff (rst)
    timerGateSelect != GATE_OFF |=> stat1Ff[S1_TACT_B] == $past(timerGateEnabled))
    else $error("gated timer active wrong");
endmodule

// ==== reader_error_status_regs_tb.sv ====
// Self-checking bench for the reader error and status register group.
// Drives every port itself on the falling edge; no partner model.
`timescale 1ns/1ps
module reader_error_status_regs_tb;
  import rdes_pkg::*;
  logic clk = 0, rst = 1, regWr = 0, cmdStart = 0, dieOverLimit = 0, authSuccess = 0;
  logic checksumBusy = 1, checksumComputeCmd = 0, checksumDone = 0;
  logic timerRun = 0, timerGateEnabled = 0;
  logic busFilterFastForce, cipherActive, irqPending;
  logic [5:0] regAddr = 6'h00, fifoWatermark = 6'h00;
  logic [7:0] regWrData = 8'h00, regRdData, faultSet = 8'h00, rd, e;
  logic [7:0] mainIrqReq = 8'h00, mainIrqEnables = 8'h00;
  logic [7:0] miscIrqReq = 8'h00, miscIrqEnables = 8'h00;
  logic [15:0] checksumResult = 16'h0000, lf = 16'he09c;
  logic [6:0] fifoByteCount = 7'h00;
  logic [6:0] corner [5] = '{7'h3c, 7'h3b, 7'h04, 7'h05, 7'h40};
  logic [2:0] radioFsmState = 3'h0;
  logic [1:0] timerGateSelect = 2'h0;
  int fails = 0, num_checks = 0;
  always #2.5 clk = ~clk;
  rdes_status_regs i_dut (.clk, .rst, .regAddr, .regWr, .regWrData, .regRdData,
    .cmdStart, .faultSet, .dieOverLimit, .checksumBusy, .checksumResult,
    .checksumComputeCmd, .checksumDone, .mainIrqReq, .mainIrqEnables, .miscIrqReq,
    .miscIrqEnables, .timerRun, .timerGateSelect, .timerGateEnabled, .fifoByteCount,
    .fifoWatermark, .radioFsmState, .authSuccess, .busFilterFastForce, .cipherActive,
    .irqPending);
  // ----
  // Helpers
  // ----
  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [7:0] s1Exp(input logic cdone);
    logic [7:0] v;
    v = 8'h00;
    v[6] = !checksumBusy && checksumResult == 16'h0000;
    v[5] = cdone;
    v[4] = |(mainIrqReq & mainIrqEnables) || |(miscIrqReq & miscIrqEnables);
    v[3] = (timerGateSelect != GATE_OFF) ? timerGateEnabled : timerRun;
    v[1] = (7'h40 - fifoByteCount) <= {1'b0, fifoWatermark};
    v[0] = fifoByteCount <= {1'b0, fifoWatermark};
    return v;
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Read data lags the inputs by two edges; a third keeps clear of the race
  task automatic rdReg(input logic [5:0] a);
    regAddr = a;
    repeat (3) @(negedge clk);
    rd = regRdData;
  endtask
  task automatic wrReg(input logic [5:0] a, input logic [7:0] d);
    regAddr = a;
    regWr = 1;
    regWrData = d;
    @(negedge clk);
    regWr = 0;
  endtask
  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict;
  end
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (10) @(negedge clk);
    rst = 0;
    rdReg(ERR_ADDR);
    chk(rd, ERR_RST);
    rdReg(STAT1_ADDR);
    chk(rd, STAT1_RST);
    rdReg(STAT2_ADDR);
    chk(rd, STAT2_RST);
    rdReg(6'h3f);
    chk(rd, 8'h00);
    $display("Test reset done");
    faultSet = 8'hff;
    @(negedge clk);
    faultSet = 8'h00;
    wrReg(ERR_ADDR, 8'h00);
    rdReg(ERR_ADDR);
    chk(rd, ERR_USED_MASK);
    cmdStart = 1;
    @(negedge clk);
    cmdStart = 0;
    rdReg(ERR_ADDR);
    chk(rd, 8'h40);
    rdReg(STAT1_ADDR);
    chk(rd & 8'h20, 8'h00);
    dieOverLimit = 1;
    wrReg(STAT2_ADDR, 8'h80);
    rdReg(ERR_ADDR);
    chk(rd, 8'h40);
    dieOverLimit = 0;
    wrReg(STAT2_ADDR, 8'h80);
    rdReg(ERR_ADDR);
    chk(rd, 8'h00);
    checksumComputeCmd = 1;
    @(negedge clk);
    checksumComputeCmd = 0;
    checksumDone = 1;
    @(negedge clk);
    checksumDone = 0;
    rdReg(STAT1_ADDR);
    chk(rd & 8'h20, 8'h20);
    $display("Test faults done");
    // Setting the cipher bit by write must not turn it on
    wrReg(STAT2_ADDR, 8'h08);
    rdReg(STAT2_ADDR);
    chk(rd, 8'h00);
    authSuccess = 1;
    @(negedge clk);
    authSuccess = 0;
    wrReg(STAT2_ADDR, 8'h7f);
    rdReg(STAT2_ADDR);
    chk(rd, 8'h48);
    chk({busFilterFastForce, cipherActive, 6'h00}, 8'hc0);
    wrReg(STAT2_ADDR, 8'h00);
    rdReg(STAT2_ADDR);
    chk({rd[7:3], busFilterFastForce, cipherActive, 1'b0}, 8'h00);
    $display("Test control done");
    for (int i = 0; i < 40; i++) begin
      lf = nxt(lf);
      fifoByteCount = {1'b0, lf[5:0]} + {6'h00, lf[6]};
      fifoWatermark = lf[11:6];
      if (i < 5) begin
        fifoByteCount = corner[i];
        fifoWatermark = 6'h04;
      end
      checksumBusy = lf[12];
      checksumResult = {14'h0000, lf[14:13]};
      timerRun = lf[15];
      timerGateEnabled = lf[0];
      timerGateSelect = lf[2:1];
      lf = nxt(lf);
      mainIrqReq = lf[7:0];
      mainIrqEnables = lf[15:8] & {8{lf[3]}};
      miscIrqReq = lf[15:8];
      miscIrqEnables = lf[7:0] & {8{lf[1] & lf[2]}};
      radioFsmState = 3'(i % 7);
      wrReg(STAT1_ADDR, lf[7:0]);
      rdReg(STAT1_ADDR);
      e = s1Exp(1'b1);
      chk(rd, e);
      chk({7'h00, irqPending}, {7'h00, e[4]});
      rdReg(STAT2_ADDR);
      chk(rd, {5'h00, radioFsmState});
    end
    $display("Test random done");
    // Reset in mid-run must drop the fault and the written controls
    radioFsmState = 3'h0;
    wrReg(STAT2_ADDR, 8'hc0);
    faultSet = 8'hff;
    @(negedge clk);
    faultSet = 8'h00;
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    rdReg(ERR_ADDR);
    chk(rd, ERR_RST);
    rdReg(STAT2_ADDR);
    chk(rd, STAT2_RST);
    $display("Test reset again done");
    print_verdict;
  end
endmodule
